// *** ets_delay_filter.sv ***
// input delay filter: output follows input after it held for limit cycles
`timescale 1ns/1ns
module ets_delay_filter (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clk_en,
  ets_flt_if.filt fl
);

  typedef struct packed {
    logic [ets_pkg::CNT_W-1:0] cnt;
    logic level;
  } ets_flt_st_t;

  localparam ets_flt_st_t FLT_RST = '{cnt: '0, level: 1'b0};

  ets_flt_st_t st_reg;
  ets_flt_st_t st_next;

  // ----------------------------------------------------------------------
  // peak suppression
  // ----------------------------------------------------------------------
  // a peak shorter than the limit restarts the count and never passes
  always_comb begin
    st_next = st_reg;
    if (fl.raw == st_reg.level) begin
      st_next.cnt = '0;
    end else if (st_reg.cnt + 1'b1 >= fl.limit) begin
      st_next.level = fl.raw;
      st_next.cnt = '0;
    end else begin
      st_next.cnt = st_reg.cnt + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_reg <= FLT_RST;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  assign fl.filtered = st_reg.level;

endmodule // ets_delay_filter

// *** ets_edge_timestamp.sv ***
// two-channel edge timestamp input with process image and record access
// What this block does
// - input image length fixed by variant
// - output image length always zero
// - selectable input delay, six legal codes
// - rising-edge enable byte, bit per input
// - falling-edge enable byte, bit per input
// - enabled edge stores tick and input states
// - newest entry at offset zero, others shift
// - small variant keeps five entries, oldest lost
// - overflow discards entries in arrival order
// - large variant keeps fifteen entries
// - no interrupts; diagnostics are read only
// - record set 01h full, 00h first four
// - index 2F01h full, 2F00h first four
// - module information reads digital, channel info
// - channel type 70h, bit seven zero
// - diagnostic bits per channel read zero
// - channel count reads two
// - diagnostic read captures 32-bit ticker
`timescale 1ns/1ns
module ets_edge_timestamp #(
  parameter bit LARGE_VARIANT = 1'b0,
  parameter int CLK_PER_US = ets_pkg::CLK_MHZ,
  parameter int ENTRIES = LARGE_VARIANT ? 15 : 5
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic [ets_pkg::CHANNELS-1:0] digital_input_n,
  input wire logic [31:0] us_tick,
  input wire logic pii_rd,
  input wire logic [5:0] pii_addr,
  output logic [7:0] pii_rdata,
  input wire logic rec_req,
  input wire logic rec_wr,
  input wire logic rec_by_index,
  input wire logic [15:0] record_set_number,
  input wire logic [7:0] rec_byte,
  input wire logic [7:0] rec_wdata,
  output logic rec_ack,
  output logic rec_err,
  output logic [7:0] rec_rdata
);

  localparam int CH = ets_pkg::CHANNELS;
  localparam logic [7:0] IMG_LEN = LARGE_VARIANT ? ets_pkg::IMG_LEN_LARGE
                                                 : ets_pkg::IMG_LEN_SMALL;

  typedef struct packed {
    logic [CH-1:0] sync1;
    logic [CH-1:0] sync2;
    logic [CH-1:0] prev;
    logic [CH-1:0][7:0] delay;
    logic [7:0] rise_en;
    logic [7:0] fall_en;
    logic [7:0] seq;
    logic [ENTRIES-1:0][ets_pkg::ENTRY_W-1:0] entries;
    logic [31:0] tick_cap;
    logic ack;
    logic err;
    logic [7:0] rdata;
    logic [7:0] pdata;
  } ets_st_t;

  localparam ets_st_t ST_RST = '{
    sync1: '0,
    sync2: '0,
    prev: '0,
    delay: {CH{ets_pkg::DELAY_RST}},
    rise_en: ets_pkg::EDGE_RST,
    fall_en: ets_pkg::EDGE_RST,
    seq: 8'h00,
    entries: '0,
    tick_cap: 32'h0000_0000,
    ack: 1'b0,
    err: 1'b0,
    rdata: 8'h00,
    pdata: 8'h00
  };

  // a low clk_en holds every field, filters and synchronisers included
  ets_st_t st_reg;
  ets_st_t st_next;
  logic [CH-1:0] filt;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [ets_pkg::CNT_W-1:0] delay_cycles(
    input logic [7:0] code);
    logic [31:0] c;
    c = 32'(ets_pkg::delay_us(code)) * 32'(CLK_PER_US);
    if (c == 32'h0000_0000) begin
      c = 32'h0000_0001;
    end
    return c[ets_pkg::CNT_W-1:0];
  endfunction

  function automatic logic legal_delay(input logic [7:0] code);
    return ets_pkg::delay_us(code) != 12'h000;
  endfunction

  // reserved enable bits are stored as zero, so they read back as zero
  function automatic logic [7:0] edge_mask(input logic [7:0] v);
    return v & ets_pkg::EDGE_MASK;
  endfunction

  // the short record is the first four bytes of the full one
  function automatic logic [7:0] diag_len(input logic first_four);
    return first_four ? ets_pkg::DIAG_SHORT_LEN : ets_pkg::DIAG_FULL_LEN;
  endfunction

  // one entry: tick low half, sequence number, filtered input states
  function automatic logic [ets_pkg::ENTRY_W-1:0] make_entry(
    input logic [15:0] tick,
    input logic [7:0] seq,
    input logic [CH-1:0] states);
    return {tick, seq, {(8 - CH){1'b0}}, states};
  endfunction

  // offsets past the image length or the kept entries read zero
  function automatic logic [7:0] image_byte(
    input logic [5:0] addr,
    input logic [ENTRIES-1:0][ets_pkg::ENTRY_W-1:0] ents);
    logic [3:0] slot;
    logic [1:0] lane;
    logic [7:0] b;
    slot = addr[5:2];
    lane = addr[1:0];
    b = 8'h00;
    if (8'(addr) < IMG_LEN && 32'(slot) < ENTRIES) begin
      b = ents[slot][8 * lane +: 8];
    end
    return b;
  endfunction

  // fixed diagnostic record; reserved bytes fall through to zero
  function automatic logic [7:0] diag_byte(input logic [7:0] idx,
                                           input logic [31:0] tick);
    logic [7:0] b;
    b = 8'h00;
    if (idx == ets_pkg::DIAG_MODINFO_OFS) begin
      b = ets_pkg::MODULE_INFO;
    end else if (idx == ets_pkg::DIAG_CHTYPE_OFS) begin
      b = ets_pkg::CHAN_TYPE;
    end else if (idx == ets_pkg::DIAG_BITS_OFS) begin
      b = ets_pkg::DIAG_BITS;
    end else if (idx == ets_pkg::DIAG_CHCNT_OFS) begin
      b = ets_pkg::CHAN_COUNT;
    end else if (idx >= ets_pkg::DIAG_TICK_OFS &&
                 idx < ets_pkg::DIAG_FULL_LEN) begin
      b = tick[8 * (idx - ets_pkg::DIAG_TICK_OFS) +: 8];
    end
    return b;
  endfunction

  // ----------------------------------------------------------------------
  // input delay filters
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < CH; g++) begin : g_flt
      ets_flt_if fl ();
      assign fl.raw = st_reg.sync2[g];
      // limit follows the live code, so a rewrite retimes a count in flight
      assign fl.limit = delay_cycles(st_reg.delay[g]);
      assign filt[g] = fl.filtered;
      ets_delay_filter u_flt (
        .core_clk(core_clk),
        .srst(srst),
        .clk_en(clk_en),
        .fl(fl)
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic [CH-1:0] rise;
    logic [CH-1:0] fall;
    logic [ets_pkg::ENTRY_W-1:0] entry;
    logic diag_short;
    logic diag_full;
    rise = '0;
    fall = '0;
    entry = '0;
    diag_short = 1'b0;
    diag_full = 1'b0;
    st_next = st_reg;
    st_next.ack = 1'b0;
    st_next.err = 1'b0;

    // ----------------------------------------------------------------------
    // synchronisers
    // ----------------------------------------------------------------------
    // pins are asynchronous: two flops before anything looks at them
    st_next.sync1 = digital_input_n;
    st_next.sync2 = st_reg.sync1;

    // ----------------------------------------------------------------------
    // edge capture
    // ----------------------------------------------------------------------
    // edges on the filtered level only, so rejected peaks never log
    st_next.prev = filt;
    rise = filt & ~st_reg.prev & st_reg.rise_en[CH-1:0];
    fall = ~filt & st_reg.prev & st_reg.fall_en[CH-1:0];
    // simultaneous edges on both inputs share one entry
    entry = make_entry(us_tick[15:0], st_reg.seq, filt);
    if (|(rise | fall)) begin
      // shift toward higher offsets; top entry falls out first
      st_next.entries = {st_reg.entries[ENTRIES-2:0], entry};
      st_next.seq = st_reg.seq + 8'h01;
    end

    // ----------------------------------------------------------------------
    // process image read
    // ----------------------------------------------------------------------
    // entry n sits at byte 4n; the read data holds between strobes
    if (pii_rd) begin
      st_next.pdata = image_byte(pii_addr, st_reg.entries);
    end

    // ----------------------------------------------------------------------
    // record and object access
    // ----------------------------------------------------------------------
    if (rec_req) begin
      st_next.ack = 1'b1;
      st_next.rdata = 8'h00;
      if (rec_by_index) begin
        diag_short = record_set_number == ets_pkg::IX_DIAG_SHORT;
        diag_full = record_set_number == ets_pkg::IX_DIAG_FULL;
      end else begin
        diag_short = record_set_number == ets_pkg::DS_DIAG_SHORT;
        // set 01h splits by direction: reads the record, writes delays
        diag_full = !rec_wr &&
                    record_set_number == ets_pkg::DS_DIAG_FULL;
      end

      if (diag_short || diag_full) begin
        // read only: a write is refused, nothing raises an event
        if (rec_wr || rec_byte >= diag_len(diag_short)) begin
          st_next.err = 1'b1;
        end else begin
          // byte 0 starts a fresh record and snapshots the ticker
          if (rec_byte == 8'h00) begin
            st_next.tick_cap = us_tick;
          end
          st_next.rdata = diag_byte(rec_byte, st_reg.tick_cap);
        end
      end else if (!rec_by_index &&
                   record_set_number == ets_pkg::DS_LENGTHS) begin
        // lengths are fixed; writes are accepted and leave them alone
        if (rec_byte == 8'h00) begin
          st_next.rdata = IMG_LEN;
        end else if (rec_byte == 8'h01) begin
          st_next.rdata = ets_pkg::OUT_IMG_LEN;
        end else begin
          st_next.err = 1'b1;
        end
      end else if (!rec_by_index &&
                   record_set_number == ets_pkg::DS_DELAY) begin
        if (rec_byte >= 8'(CH)) begin
          st_next.err = 1'b1;
        end else if (!legal_delay(rec_wdata)) begin
          st_next.err = 1'b1;
        end else begin
          st_next.delay[rec_byte[0]] = rec_wdata;
        end
      end else if (!rec_by_index &&
                   record_set_number == ets_pkg::DS_EDGES) begin
        if (rec_byte == 8'h00) begin
          st_next.rdata = st_reg.rise_en;
          if (rec_wr) begin
            st_next.rise_en = edge_mask(rec_wdata);
          end
        end else if (rec_byte == 8'h01) begin
          st_next.rdata = st_reg.fall_en;
          if (rec_wr) begin
            st_next.fall_en = edge_mask(rec_wdata);
          end
        end else begin
          st_next.err = 1'b1;
        end
      end else if (rec_by_index) begin
        // single-byte objects, one per parameter
        unique case (record_set_number)
          ets_pkg::IX_IN_LEN: st_next.rdata = IMG_LEN;
          ets_pkg::IX_OUT_LEN: st_next.rdata = ets_pkg::OUT_IMG_LEN;
          ets_pkg::IX_DELAY0, ets_pkg::IX_DELAY1: begin
            st_next.rdata = st_reg.delay[record_set_number[0]];
            if (rec_wr) begin
              if (legal_delay(rec_wdata)) begin
                st_next.delay[record_set_number[0]] = rec_wdata;
              end else begin
                st_next.err = 1'b1;
              end
            end
          end
          ets_pkg::IX_RISE: begin
            st_next.rdata = st_reg.rise_en;
            if (rec_wr) begin
              st_next.rise_en = edge_mask(rec_wdata);
            end
          end
          ets_pkg::IX_FALL: begin
            st_next.rdata = st_reg.fall_en;
            if (rec_wr) begin
              st_next.fall_en = edge_mask(rec_wdata);
            end
          end
          default: st_next.err = 1'b1;
        endcase
        if (rec_wr && (record_set_number == ets_pkg::IX_IN_LEN ||
                       record_set_number == ets_pkg::IX_OUT_LEN)) begin
          st_next.err = 1'b1;
        end
      end else begin
        st_next.err = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_reg <= ST_RST;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  // every output is a field of the state flops, never a gate after them
  assign pii_rdata = st_reg.pdata;
  assign rec_ack = st_reg.ack;
  assign rec_err = st_reg.err;
  assign rec_rdata = st_reg.rdata;

endmodule // ets_edge_timestamp

// *** ets_edge_timestamp_checker.sv ***
// port assertions of the edge timestamp input
`timescale 1ns/1ns
module ets_edge_timestamp_checker #(
  parameter bit LARGE_VARIANT = 1'b0
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic pii_rd,
  input wire logic [5:0] pii_addr,
  input wire logic [7:0] pii_rdata,
  input wire logic rec_req,
  input wire logic rec_wr,
  input wire logic rec_by_index,
  input wire logic [15:0] record_set_number,
  input wire logic [7:0] rec_byte,
  input wire logic [7:0] rec_wdata,
  input wire logic rec_ack,
  input wire logic rec_err,
  input wire logic [7:0] rec_rdata
);
  localparam logic [7:0] IN_LEN = LARGE_VARIANT ? 8'h3c : 8'h14;
  localparam int IMG_BYTES = LARGE_VARIANT ? 60 : 20;
  logic take, rd_set, rd_diag, wr_diag, bad_dly;
  assign take = rec_req && clk_en;
  assign rd_set = take && !rec_wr && !rec_by_index;
  assign rd_diag = rd_set && record_set_number == 16'h0001;
  assign wr_diag = take && rec_wr && (rec_by_index ?
    (record_set_number inside {16'h2f00, 16'h2f01}) :
    record_set_number == 16'h0000);
  assign bad_dly = take && rec_wr && !rec_by_index && rec_byte < 8'h02 &&
    record_set_number == 16'h0001 &&
    !(rec_wdata inside {8'h00, 8'h02, 8'h04, 8'h07, 8'h09, 8'h0c});
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);
  a_ack_next: assert property (
    take ##1 clk_en |-> rec_ack) else $error("request not acked");
  a_ack_only_req: assert property (
    !take ##1 clk_en |-> !rec_ack) else $error("ack without request");
  a_err_with_ack: assert property (
    rec_err |-> rec_ack) else $error("error without ack");
  a_diag_wr_refused: assert property (
    wr_diag ##1 clk_en |-> rec_err) else $error("diag write accepted");
  a_bad_delay: assert property (
    bad_dly ##1 clk_en |-> rec_err) else $error("bad delay accepted");
  a_module_info: assert property (
    rd_diag && rec_byte == 8'h01 |=> rec_rdata == 8'h1f)
    else $error("module info wrong");
  a_channel_type: assert property (
    rd_diag && rec_byte == 8'h04 |=> rec_rdata == 8'h70)
    else $error("channel type wrong");
  a_channel_count: assert property (
    rd_diag && rec_byte == 8'h06 |=> rec_rdata == 8'h02)
    else $error("channel count wrong");
  a_reserved_zero: assert property (
    rd_diag && rec_byte inside {[8'h00:8'h03], 8'h05, [8'h07:8'h0f]} &&
    rec_byte != 8'h01 |=> rec_rdata == 8'h00 && !rec_err)
    else $error("reserved diag byte not zero");
  a_in_len_fixed: assert property (
    rd_set && record_set_number == 16'h0002 && rec_byte == 8'h00
    |=> rec_rdata == IN_LEN) else $error("input length wrong");
  a_out_len_zero: assert property (
    rd_set && record_set_number == 16'h0002 && rec_byte == 8'h01
    |=> rec_rdata == 8'h00) else $error("output length not zero");
  a_image_bound: assert property (
    pii_rd && clk_en && pii_addr >= IMG_BYTES |=> pii_rdata == 8'h00)
    else $error("image beyond length not zero");
  c_tick_read: cover property (rd_diag && rec_byte == 8'h10);
  c_refused: cover property (rec_err);
  c_entry: cover property (pii_rd && pii_addr == 6'h00 ##2 pii_rdata != 0);
endmodule // ets_edge_timestamp_checker

bind ets_edge_timestamp ets_edge_timestamp_checker #(
  .LARGE_VARIANT(LARGE_VARIANT)) i_ets_edge_timestamp_checker (
  .core_clk(core_clk), .srst(srst), .clk_en(clk_en), .pii_rd(pii_rd),
  .pii_addr(pii_addr), .pii_rdata(pii_rdata), .rec_req(rec_req),
  .rec_wr(rec_wr), .rec_by_index(rec_by_index),
  .record_set_number(record_set_number), .rec_byte(rec_byte),
  .rec_wdata(rec_wdata), .rec_ack(rec_ack), .rec_err(rec_err),
  .rec_rdata(rec_rdata));

// *** ets_edge_timestamp_test.sv ***
// self-checking bench of the edge timestamp input
`timescale 1ns/1ns
module ets_edge_timestamp_test;
  localparam int CPU = 2;
  logic core_clk, srst, clk_en, pii_rd, rec_req, rec_wr, rec_by_index;
  logic rec_ack, rec_err, err;
  logic [1:0] din, rise_en, fall_en;
  logic [5:0] pii_addr;
  logic [7:0] pii_rdata, rec_byte, rec_wdata, rec_rdata, d, s0, wd;
  logic [15:0] record_set_number, sn;
  logic [31:0] us_tick, cap;
  logic [7:0] exp_q[$];
  logic [15:0] exp_t[$];
  int num_errors, checks_done, seed;

  ets_tick_model #(.CLK_PER_US(CPU)) i_ets_tick_model (
    .core_clk(core_clk), .srst(srst), .us_tick(us_tick));
  ets_edge_timestamp #(.LARGE_VARIANT(1'b0), .CLK_PER_US(CPU))
    i_ets_edge_timestamp (.core_clk(core_clk), .srst(srst), .clk_en(clk_en),
    .digital_input_n(din), .us_tick(us_tick), .pii_rd(pii_rd),
    .pii_addr(pii_addr), .pii_rdata(pii_rdata), .rec_req(rec_req),
    .rec_wr(rec_wr), .rec_by_index(rec_by_index),
    .record_set_number(record_set_number), .rec_byte(rec_byte),
    .rec_wdata(rec_wdata), .rec_ack(rec_ack), .rec_err(rec_err),
    .rec_rdata(rec_rdata));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------------
  // tasks and expectations
  // ----------------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // entered at a falling edge; ack and error stand one cycle, look there
  task automatic rec(input logic w, input logic x, input logic [15:0] sn,
      input logic [7:0] b, input logic [7:0] wdat, input logic e);
    rec_wr = w;
    rec_by_index = x;
    record_set_number = sn;
    rec_byte = b;
    rec_wdata = wdat;
    rec_req = 1'b1;
    @(negedge core_clk);
    chk({7'h00, rec_ack}, 8'h01);
    chk({7'h00, rec_err}, {7'h00, e});
    d = rec_rdata;
    rec_req = 1'b0;
    @(negedge core_clk);
  endtask

  task automatic input_process_image(input int a);
    pii_addr = 6'(a);
    pii_rd = 1'b1;
    @(negedge core_clk);
    pii_rd = 1'b0;
    @(negedge core_clk);
    d = pii_rdata;
  endtask

  function automatic logic [7:0] diag_exp(input int b, input logic [31:0] t);
    case (b)
      1: return 8'h1f;
      4: return 8'h70;
      6: return 8'h02;
      16, 17, 18, 19: return t[8*(b-16) +: 8];
      default: return 8'h00;
    endcase
  endfunction

  // sync 2 + filter 6 cycles: the tick seen 8 falling edges on is stored
  task automatic toggle(input int c);
    din[c] = ~din[c];
    repeat (8) @(negedge core_clk);
    if ((din[c] && rise_en[c]) || (!din[c] && fall_en[c])) begin
      exp_q.push_front({6'h00, din});
      exp_t.push_front(us_tick[15:0]);
      if (exp_q.size() > 5) exp_q.pop_back();
      if (exp_t.size() > 5) exp_t.pop_back();
    end
    repeat (8) @(negedge core_clk);
  endtask

  task automatic check_image();
    for (int k = 0; k < 6; k++) begin
      input_process_image(4 * k);
      chk(d, k < exp_q.size() ? exp_q[k] : 8'h00);
      input_process_image(4 * k + 1);
      if (k == 0) s0 = d;
      else chk(d, k < exp_q.size() ? s0 - 8'(k) : 8'h00);
      input_process_image(4 * k + 2);
      chk(d, k < exp_t.size() ? exp_t[k][7:0] : 8'h00);
      input_process_image(4 * k + 3);
      chk(d, k < exp_t.size() ? exp_t[k][15:8] : 8'h00);
    end
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    #400000;
    num_errors++;
    report_and_stop();
  end

  initial begin
    seed = 87130;
    {srst, clk_en, din, pii_rd, pii_addr, rec_req} = 12'hc00;
    {rec_wr, rec_by_index, record_set_number, rec_byte, rec_wdata} = 0;
    {rise_en, fall_en} = 4'h0;
    repeat (4) @(negedge core_clk);
    srst = 1'b0;
    for (int b = 0; b < 20; b++) begin
      if (b == 0) cap = us_tick;
      rec(1'b0, 1'b0, 16'h0001, 8'(b), 8'h00, 1'b0);
      chk(d, diag_exp(b, cap));
    end
    for (int k = 0; k < 2; k++) begin
      sn = k ? 16'h2f00 : 16'h0000;
      for (int b = 0; b < 5; b++) begin
        rec(1'b0, k[0], sn, 8'(b), 8'h00, b == 4);
        if (b < 4) chk(d, diag_exp(b, cap));
      end
      rec(1'b1, k[0], sn | 16'(k), 8'h00, 8'h55, 1'b1);
    end
    rec(1'b0, 1'b1, 16'h2f01, 8'h06, 8'h00, 1'b0);
    chk(d, 8'h02);
    rec(1'b1, 1'b0, 16'h0002, 8'h00, 8'h3c, 1'b0);
    rec(1'b0, 1'b0, 16'h0002, 8'h00, 8'h00, 1'b0);
    chk(d, 8'h14);
    rec(1'b0, 1'b1, 16'h3101, 8'h00, 8'h00, 1'b0);
    chk(d, 8'h00);
    rec(1'b1, 1'b1, 16'h3100, 8'h00, 8'h3c, 1'b1);
    wd = 8'h02;
    for (int c = 0; c < 16; c++) begin
      err = !(c inside {0, 2, 4, 7, 9, 12});
      rec(1'b1, 1'b0, 16'h0001, 8'h00, 8'(c), err);
      if (!err) wd = 8'(c);
      rec(1'b0, 1'b1, 16'h3102, 8'h00, 8'h00, 1'b0);
      chk(d, wd);
    end
    rec(1'b1, 1'b1, 16'h3102, 8'h00, 8'h02, 1'b0);
    rec(1'b1, 1'b0, 16'h0080, 8'h00, 8'h03, 1'b0);
    rise_en = 2'b11;
    // pulse shorter than the filter must leave no entry
    din[0] = 1'b1;
    repeat (3) @(negedge core_clk);
    din[0] = 1'b0;
    repeat (20) @(negedge core_clk);
    check_image();
    for (int r = 0; r < 4; r++) begin
      wd = (r == 0) ? 8'h01 : 8'($random(seed));
      rec(1'b1, 1'b1, 16'h3104, 8'h00, wd, 1'b0);
      rise_en = wd[1:0];
      rec(1'b0, 1'b1, 16'h3104, 8'h00, 8'h00, 1'b0);
      chk(d, wd & 8'h03);
      wd = (r == 0) ? 8'h02 : 8'($random(seed));
      rec(1'b1, 1'b0, 16'h0080, 8'h01, wd, 1'b0);
      fall_en = wd[1:0];
      rec(1'b0, 1'b0, 16'h0080, 8'h01, 8'h00, 1'b0);
      chk(d, wd & 8'h03);
      for (int n = 0; n < 9; n++) toggle($random(seed) & 1);
      check_image();
    end
    // a frozen clock enable must keep a long pulse out of the image
    rec(1'b1, 1'b1, 16'h3104, 8'h00, 8'h03, 1'b0);
    rec(1'b1, 1'b1, 16'h3105, 8'h00, 8'h03, 1'b0);
    {rise_en, fall_en} = 4'hf;
    clk_en = 1'b0;
    din[1] = ~din[1];
    repeat (20) @(negedge core_clk);
    din[1] = ~din[1];
    clk_en = 1'b1;
    repeat (16) @(negedge core_clk);
    check_image();
    report_and_stop();
  end
endmodule // ets_edge_timestamp_test

// *** ets_flt_if.sv ***
// link between the edge block and one input delay filter
`timescale 1ns/1ns
interface ets_flt_if;
  logic raw;
  logic [ets_pkg::CNT_W-1:0] limit;
  logic filtered;
  modport ctrl (output raw, output limit, input filtered);
  modport filt (input raw, input limit, output filtered);
endinterface

// *** ets_pkg.sv ***
// constants, record map and helpers for the edge timestamp input block
package ets_pkg;

  // ----------------------------------------------------------------------
  // clocking and timing
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int CNT_W = 24;
  localparam int CHANNELS = 2;

  // ----------------------------------------------------------------------
  // image lengths and entry layout
  // ----------------------------------------------------------------------
  localparam logic [7:0] IMG_LEN_SMALL = 8'h14;
  localparam logic [7:0] IMG_LEN_LARGE = 8'h3c;
  localparam logic [7:0] OUT_IMG_LEN = 8'h00;
  localparam int ENTRY_BYTES = 4;
  localparam int ENTRY_W = 32;

  // ----------------------------------------------------------------------
  // record set numbers and object indexes
  // ----------------------------------------------------------------------
  localparam logic [15:0] DS_DIAG_SHORT = 16'h0000;
  localparam logic [15:0] DS_DIAG_FULL = 16'h0001;
  localparam logic [15:0] DS_DELAY = 16'h0001;
  localparam logic [15:0] DS_LENGTHS = 16'h0002;
  localparam logic [15:0] DS_EDGES = 16'h0080;
  localparam logic [15:0] IX_DIAG_SHORT = 16'h2f00;
  localparam logic [15:0] IX_DIAG_FULL = 16'h2f01;
  localparam logic [15:0] IX_IN_LEN = 16'h3100;
  localparam logic [15:0] IX_OUT_LEN = 16'h3101;
  localparam logic [15:0] IX_DELAY0 = 16'h3102;
  localparam logic [15:0] IX_DELAY1 = 16'h3103;
  localparam logic [15:0] IX_RISE = 16'h3104;
  localparam logic [15:0] IX_FALL = 16'h3105;

  // ----------------------------------------------------------------------
  // register reset values and field layout
  // ----------------------------------------------------------------------
  localparam logic [7:0] DELAY_RST = 8'h02;
  localparam logic [7:0] EDGE_RST = 8'h00;
  localparam logic [7:0] EDGE_MASK = 8'h03;
  localparam logic [7:0] MODULE_INFO = 8'h1f;
  localparam logic [7:0] CHAN_TYPE = 8'h70;
  localparam logic [7:0] DIAG_BITS = 8'h00;
  localparam logic [7:0] CHAN_COUNT = 8'h02;
  localparam logic [7:0] DIAG_SHORT_LEN = 8'h04;
  localparam logic [7:0] DIAG_FULL_LEN = 8'h14;
  localparam logic [7:0] DIAG_TICK_OFS = 8'h10;
  localparam logic [7:0] DIAG_MODINFO_OFS = 8'h01;
  localparam logic [7:0] DIAG_CHTYPE_OFS = 8'h04;
  localparam logic [7:0] DIAG_BITS_OFS = 8'h05;
  localparam logic [7:0] DIAG_CHCNT_OFS = 8'h06;

  // ----------------------------------------------------------------------
  // input delay codes and their times in microseconds
  // ----------------------------------------------------------------------
  localparam logic [7:0] DLY_C1 = 8'h00;
  localparam logic [7:0] DLY_C3 = 8'h02;
  localparam logic [7:0] DLY_C10 = 8'h04;
  localparam logic [7:0] DLY_C86 = 8'h07;
  localparam logic [7:0] DLY_C342 = 8'h09;
  localparam logic [7:0] DLY_C2731 = 8'h0c;
  localparam int DLY_US1 = 1;
  localparam int DLY_US3 = 3;
  localparam int DLY_US10 = 10;
  localparam int DLY_US86 = 86;
  localparam int DLY_US342 = 342;
  localparam int DLY_US2731 = 2731;

  // delay code to time in microseconds, zero for an illegal code
  function automatic logic [11:0] delay_us(input logic [7:0] code);
    logic [11:0] us;
    us = 12'h000;
    case (code)
      DLY_C1: us = 12'(DLY_US1);
      DLY_C3: us = 12'(DLY_US3);
      DLY_C10: us = 12'(DLY_US10);
      DLY_C86: us = 12'(DLY_US86);
      DLY_C342: us = 12'(DLY_US342);
      DLY_C2731: us = 12'(DLY_US2731);
      default: us = 12'h000;
    endcase
    return us;
  endfunction

endpackage

// *** ets_tick_model.sv ***
// microsecond ticker of the head module that feeds the block
`timescale 1ns/1ns
module ets_tick_model #(
  parameter int CLK_PER_US = 125
) (
  input wire logic core_clk,
  input wire logic srst,
  output logic [31:0] us_tick
);
  int div;
  // starts near a 16-bit wrap so the low half wraps early in a run, before the first entry is stored
  always_ff @(posedge core_clk) begin
    if (srst) begin
      div <= 0;
      us_tick <= 32'h0000fff0;
    end else if (div == CLK_PER_US - 1) begin
      div <= 0;
      us_tick <= us_tick + 32'h00000001;
    end else begin
      div <= div + 1;
    end
  end
endmodule // ets_tick_model
